// ---- verilog/cspc_map.svh ----
`ifndef CSPC_MAP_SVH
`define CSPC_MAP_SVH
`define CSPC_IDX_CTRL       7'h00
`define CSPC_IDX_STATUS     7'h01
`define CSPC_IDX_HOST       7'h02
`define CSPC_IDX_INTR       7'h5F
`define CSPC_CTRL_RESET     8'h01
`define CSPC_CTRL_MASK      8'h4F
`define CSPC_CTRL_INIT      0
`define CSPC_CTRL_IE        1
`define CSPC_CTRL_SIE       2
`define CSPC_CTRL_EIE       3
`define CSPC_CTRL_CCE       6
`define CSPC_ST_LEC_LSB     0
`define CSPC_ST_TX_SUCCESS_FLAG        3
`define CSPC_ST_RX_SUCCESS_FLAG        4
`define CSPC_ST_WAKE        5
`define CSPC_ST_WARN        6
`define CSPC_ST_BUS_OFF_FLAG        7
`define CSPC_HOST_RESET     8'h61
`define CSPC_HOST_IN_RESET  8'hE1
`define CSPC_HOST_MASK      8'h7D
`define CSPC_HOST_CEN       0
`define CSPC_HOST_MUX       2
`define CSPC_HOST_SLEEP     3
`define CSPC_HOST_PWD       4
`define CSPC_HOST_DMC       5
`define CSPC_HOST_DSC       6
`define CSPC_HOST_HW_RESET_STATUS     7
`define CSPC_LIMIT_BUS_OFF_FLAG     9'h100
`define CSPC_LIMIT_WARN     9'h060
`define CSPC_LEC_NONE       3'h0
`define CSPC_LEC_UNUSED     3'h7
`define CSPC_LEC_RECOVERY   3'h5
`define CSPC_RUN_BITS       4'hB
`define CSPC_RUN_GROUPS     8'h80
`define CSPC_RESET_HOLD     5'h10
`define CSPC_INT_STATUS     8'h01
`define CSPC_INT_OBJ_BASE   8'h02
`define CSPC_SETTLE_MS      10
`define CSPC_CLK_MHZ        100
`define CSPC_SETTLE_CYC     (`CSPC_SETTLE_MS * 1000 * `CSPC_CLK_MHZ)
`endif

// ---- verilog/cspc_pkg.sv ----
package cspc_pkg;
  typedef enum logic [1:0] {
    CSPC_RUN,
    CSPC_SLEEP,
    CSPC_PDOWN
  } cspc_mode_type;

  typedef struct packed {
    logic       frame_start;
    logic       frame_error;
    logic [2:0] error_code;
    logic       rx_ok;
    logic       tx_ok;
    logic       bit_strobe;
    logic       bit_recessive;
  } cspc_bus_evt_type;

  typedef struct packed {
    logic [8:0] tx_count;
    logic [8:0] rx_count;
  } cspc_err_cnt_type;
endpackage

// ---- verilog/cspc_recovery.sv ----
`timescale 1ns/1ps
`include "cspc_map.svh"
module cspc_recovery (
  // Clock and reset.
  input  wire logic clk,
  input  wire logic rst_n,
  // Control and bus bits.
  input  wire logic active,
  input  wire logic bit_strobe,
  input  wire logic bit_recessive,
  // Results.
  output logic      run_seen,
  output logic      done
);
  logic [3:0] run_bits;
  logic [7:0] groups;

  // A dominant bit restarts the run, so only idle bus time counts.
  always_ff @(posedge clk) begin
    run_seen <= 1'b0;
    done     <= 1'b0;
    if (!rst_n || !active) begin
      run_bits <= 4'h0;
      groups   <= 8'h00;
    end else if (bit_strobe) begin
      if (!bit_recessive) begin
        run_bits <= 4'h0;
      end else if (run_bits == `CSPC_RUN_BITS - 4'h1) begin
        run_bits <= 4'h0;
        run_seen <= 1'b1;
        groups   <= groups + 8'h01;
        done     <= (groups == `CSPC_RUN_GROUPS - 8'h01); // RQ2
      end else begin
        run_bits <= run_bits + 4'h1;
      end
    end
  end

  property p_done_after_groups;
    @(posedge clk) disable iff (!rst_n)
    done |-> $past(groups) == 8'h7F && $past(run_bits) == 4'hA;
  endproperty
  a_done_after_groups: assert property (p_done_after_groups) // RQ2
    else $error("Recovery ended before 128 runs of 11 bits.");
endmodule

// ---- verilog/cspc_clock_div.sv ----
`timescale 1ns/1ps
module cspc_clock_div (
  // Clock and reset.
  input  wire logic clk,
  input  wire logic rst_n,
  // Settings.
  input  wire logic system_clock_halver,
  input  wire logic memory_clock_halver,
  input  wire logic clock_output_enable,
  input  wire logic stop,
  // Clock ticks and pin.
  output logic      system_tick,
  output logic      memory_tick,
  output logic      clock_out
);
  logic sys_phase;
  logic mem_phase;
  logic next_sys;

  always_comb begin
    next_sys = !system_clock_halver || sys_phase; // RQ16
  end

  // Ticks are enables rather than derived clocks, so one domain remains.
  always_ff @(posedge clk) begin
    if (!rst_n || stop) begin
      sys_phase   <= 1'b0;
      mem_phase   <= 1'b0;
      system_tick <= 1'b0;
      memory_tick <= 1'b0;
    end else begin
      sys_phase   <= !sys_phase;
      system_tick <= next_sys;
      if (next_sys) begin
        mem_phase <= !mem_phase;
      end
      memory_tick <= next_sys && (!memory_clock_halver || mem_phase); // RQ16
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n || stop || !clock_output_enable) begin
      clock_out <= 1'b0; // RQ17 RQ19
    end else if (next_sys) begin
      clock_out <= !clock_out;
    end
  end

  property p_clock_out_gated;
    @(posedge clk) disable iff (!rst_n)
    (!clock_output_enable || stop) |=> !clock_out;
  endproperty
  a_clock_out_gated: assert property (p_clock_out_gated) // RQ17
    else $error("Clock output toggled while gated.");
endmodule

// ---- verilog/cspc_core.sv ----
// Overview of operation
// RQ1 - Bus-off at count 256 stops frame traffic
// RQ2 - Recovery clears counters, waits 128 idle runs
// RQ3 - Warning flag set at count 96
// RQ4 - Warning interrupts need error and global enables
// RQ5 - Wake flag low asleep, set on exit
// RQ6 - Any clean frame sets receive flag
// RQ7 - Acknowledged own frame sets transmit flag
// RQ8 - Error code holds first error, cleared clean
// RQ9 - Error codes one through six defined
// RQ10 - Recovery writes code five per idle run
// RQ11 - Status read drops status interrupt
// RQ12 - Every success raises enabled status interrupt
// RQ13 - Object interrupts served in fixed priority
// RQ14 - Host register reads E1 in reset, 61 after
// RQ15 - Reset status set, other access refused
// RQ16 - Halver bits divide system and memory clocks
// RQ17 - Clock output enable gates pin, set
// RQ18 - Low speed select moves interrupt pin
// RQ19 - Low power stops oscillator and objects
// RQ20 - Power down leaves on reset or clear
// RQ21 - Sleep leaves on clear or activity, 10 ms
// RQ22 - Host configures before low power modes
// RQ23 - Going bus-off sets configuration hold
// RQ24 - Power down overrides sleep bit
//
// Chosen here: the Avalon-MM slave port.
`timescale 1ns/1ps
`include "cspc_map.svh"
module cspc_core #(
  parameter int unsigned SETTLE_CYCLES = `CSPC_SETTLE_CYC
) (
  // Clock and reset.
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  // Avalon-MM slave.
  input  wire logic [8:0]                address,
  input  wire logic                      read,
  input  wire logic                      write,
  input  wire logic [31:0]               writedata,
  input  wire logic [3:0]                byteenable,
  output logic      [31:0]               readdata,
  output logic                           waitrequest,
  // Protocol engine.
  input  wire cspc_pkg::cspc_bus_evt_type bus_evt,
  input  wire cspc_pkg::cspc_err_cnt_type err_cnt,
  output logic                           counters_reset,
  output logic                           bus_enable,
  // Message objects.
  input  wire logic [14:0]               obj_tx_event,
  input  wire logic [14:0]               obj_rx_event,
  input  wire logic [14:0]               object_tx_irq_enable,
  input  wire logic [14:0]               object_rx_irq_enable,
  output logic                           obj_access_enable,
  output logic                           config_write_unlock,
  // Pins.
  input  wire logic                      can_rx_pin,
  output logic                           int_main_n,
  output logic                           int_alt_n,
  output logic                           half_ref_enable,
  output logic                           osc_enable,
  output logic                           system_tick,
  output logic                           memory_tick,
  output logic                           clock_out
);
  logic [7:0]  ctrl;
  logic [7:0]  host_ctl;
  logic        bus_off_flag;
  logic        error_warning_flag;
  logic        wakeup_flag;
  logic        rx_success_flag;
  logic        tx_success_flag;
  logic [2:0]  last_error_code;
  logic        err_in_frame;
  logic        recovering;
  logic        stat_pend;
  logic        stat_seen;
  logic [14:0] obj_pend;
  logic [4:0]  hold_cnt;
  logic [19:0] settle_cnt;
  logic        rx_meta;
  logic        rx_sync;
  logic        warn_prev;
  logic        bus_off_flag_prev;
  logic        run_seen;
  logic        rec_done;
  cspc_pkg::cspc_mode_type mode;
  cspc_pkg::cspc_mode_type next_mode;
  logic        hold;
  logic        wr_acc;
  logic        rd_acc;
  logic [6:0]  idx;
  logic        low_power;
  logic        activity;
  logic        irq_cond;
  logic [7:0]  int_code;
  logic [7:0]  status_val;
  logic [8:0]  worst;

  function automatic logic hit(input logic [6:0] a, input logic [6:0] r);
    hit = (a == r);
  endfunction

  function automatic logic [7:0] obj_code(input logic [14:0] p);
    obj_code = 8'h00;
    for (int i = 14; i >= 0; i--) begin
      if (p[i]) begin
        obj_code = `CSPC_INT_OBJ_BASE + 8'(i);
      end
    end
  endfunction

  always_comb begin
    hold       = (hold_cnt != 5'h00);
    idx        = address[8:2];
    wr_acc     = write && !waitrequest && byteenable[0];
    rd_acc     = read && !waitrequest;
    low_power  = (mode != cspc_pkg::CSPC_RUN);
    activity   = !rx_sync;
    worst      = (err_cnt.tx_count > err_cnt.rx_count) ?
                 err_cnt.tx_count : err_cnt.rx_count;
    int_code   = stat_pend ? `CSPC_INT_STATUS : obj_code(obj_pend); // RQ13
    irq_cond   = ctrl[`CSPC_CTRL_IE] && (int_code != 8'h00);
    status_val = {bus_off_flag, error_warning_flag, wakeup_flag,
                  rx_success_flag, tx_success_flag, last_error_code};
  end

  // Power down wins over sleep whatever the sleep bit holds.
  always_comb begin
    if (host_ctl[`CSPC_HOST_PWD]) begin
      next_mode = cspc_pkg::CSPC_PDOWN; // RQ24
    end else if (host_ctl[`CSPC_HOST_SLEEP]) begin
      next_mode = cspc_pkg::CSPC_SLEEP; // RQ24
    end else begin
      next_mode = cspc_pkg::CSPC_RUN;
    end
  end

  // The pin is asynchronous to clk, so two stages precede any use.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rx_meta <= 1'b1;
      rx_sync <= 1'b1;
    end else begin
      rx_meta <= can_rx_pin;
      rx_sync <= rx_meta;
    end
  end

  // A fixed hold after release stands in for the internal reset phase.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hold_cnt <= `CSPC_RESET_HOLD; // RQ15
    end else if (hold) begin
      hold_cnt <= hold_cnt - 5'h01;
    end
  end

  // One wait cycle per access; read data settle before the accept edge.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      waitrequest <= 1'b1;
      readdata    <= 32'h0000_0000;
      stat_seen   <= 1'b0;
    end else begin
      waitrequest <= !((read || write) && waitrequest);
      if (read && waitrequest) begin
        readdata  <= 32'h0000_0000;
        stat_seen <= 1'b0;
        if (hit(idx, `CSPC_IDX_HOST)) begin
          readdata[7:0] <= {hold, host_ctl[6:0]}; // RQ14
        end else if (!hold) begin // RQ15
          if (hit(idx, `CSPC_IDX_CTRL)) begin
            readdata[7:0] <= ctrl;
          end else if (hit(idx, `CSPC_IDX_STATUS)) begin
            readdata[7:0] <= status_val;
            stat_seen     <= stat_pend;
          end else if (hit(idx, `CSPC_IDX_INTR)) begin
            readdata[7:0] <= int_code;
          end
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl <= `CSPC_CTRL_RESET;
    end else begin
      if (wr_acc && !hold && hit(idx, `CSPC_IDX_CTRL)) begin
        ctrl <= writedata[7:0] & `CSPC_CTRL_MASK;
      end
      if (!bus_off_flag && worst >= `CSPC_LIMIT_BUS_OFF_FLAG) begin
        ctrl[`CSPC_CTRL_INIT] <= 1'b1; // RQ23
      end
    end
  end

  // Reset leaves power down because the register returns to its default.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      host_ctl <= `CSPC_HOST_RESET; // RQ14 RQ17 RQ20
    end else begin
      if (wr_acc && hit(idx, `CSPC_IDX_HOST)) begin
        host_ctl <= writedata[7:0] & `CSPC_HOST_MASK; // RQ16 RQ20
      end
      if (mode == cspc_pkg::CSPC_SLEEP && activity) begin
        host_ctl[`CSPC_HOST_SLEEP] <= 1'b0; // RQ21
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mode       <= cspc_pkg::CSPC_RUN;
      settle_cnt <= 20'h0_0000;
    end else begin
      mode <= next_mode;
      case (mode)
        cspc_pkg::CSPC_SLEEP: begin
          if (activity) begin
            settle_cnt <= SETTLE_CYCLES[19:0]; // RQ21
          end
        end
        cspc_pkg::CSPC_RUN: begin
          if (settle_cnt != 20'h0_0000) begin
            settle_cnt <= settle_cnt - 20'h0_0001;
          end
        end
        default: begin
          settle_cnt <= 20'h0_0000;
        end
      endcase
    end
  end

  // The warning flag is a pure level of the counters.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      error_warning_flag <= 1'b0;
      warn_prev          <= 1'b0;
      bus_off_flag_prev          <= 1'b0;
    end else begin
      error_warning_flag <= (worst >= `CSPC_LIMIT_WARN); // RQ3
      warn_prev          <= error_warning_flag;
      bus_off_flag_prev          <= bus_off_flag;
    end
  end

  always_ff @(posedge clk) begin
    counters_reset <= 1'b0;
    if (!rst_n) begin
      bus_off_flag <= 1'b0;
      recovering   <= 1'b0;
    end else if (!bus_off_flag) begin
      bus_off_flag <= (worst >= `CSPC_LIMIT_BUS_OFF_FLAG); // RQ1
    end else if (!recovering && !ctrl[`CSPC_CTRL_INIT]) begin
      recovering     <= 1'b1; // RQ1
      counters_reset <= 1'b1; // RQ2
    end else if (rec_done) begin
      bus_off_flag <= 1'b0; // RQ2
      recovering   <= 1'b0;
    end
  end

  cspc_recovery u_recovery (
    .clk           (clk),
    .rst_n         (rst_n),
    .active        (recovering),
    .bit_strobe    (bus_evt.bit_strobe),
    .bit_recessive (bus_evt.bit_recessive),
    .run_seen      (run_seen),
    .done          (rec_done)
  );

  // A flag set in the same cycle as a host clear stays set.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rx_success_flag <= 1'b0;
      tx_success_flag <= 1'b0;
    end else begin
      if (wr_acc && !hold && hit(idx, `CSPC_IDX_STATUS)) begin
        rx_success_flag <= rx_success_flag && writedata[`CSPC_ST_RX_SUCCESS_FLAG];
        tx_success_flag <= tx_success_flag && writedata[`CSPC_ST_TX_SUCCESS_FLAG];
      end
      if (bus_evt.rx_ok) begin
        rx_success_flag <= 1'b1; // RQ6
      end
      if (bus_evt.tx_ok) begin
        tx_success_flag <= 1'b1; // RQ7
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      last_error_code <= `CSPC_LEC_NONE;
      err_in_frame    <= 1'b0;
    end else begin
      if (wr_acc && !hold && hit(idx, `CSPC_IDX_STATUS)) begin
        last_error_code <= writedata[2:0]; // RQ8
      end
      if (bus_evt.frame_start) begin
        err_in_frame <= 1'b0;
      end
      if (bus_evt.frame_error && !err_in_frame &&
          bus_evt.error_code != `CSPC_LEC_UNUSED) begin
        last_error_code <= bus_evt.error_code; // RQ8 RQ9
        err_in_frame    <= 1'b1;
      end else if (bus_evt.rx_ok || bus_evt.tx_ok) begin
        last_error_code <= `CSPC_LEC_NONE; // RQ8
      end
      if (run_seen) begin
        last_error_code <= `CSPC_LEC_RECOVERY; // RQ10
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wakeup_flag <= 1'b0;
    end else if (low_power && next_mode == cspc_pkg::CSPC_RUN) begin
      wakeup_flag <= 1'b1; // RQ5
    end else if (mode == cspc_pkg::CSPC_SLEEP) begin
      wakeup_flag <= 1'b0; // RQ5
    end else if (rd_acc && !hold && hit(idx, `CSPC_IDX_STATUS) &&
                 readdata[`CSPC_ST_WAKE]) begin
      wakeup_flag <= 1'b0; // RQ5
    end
  end

  // Only the pending state the read returned is cleared, so nothing is lost.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stat_pend <= 1'b0;
    end else if ((ctrl[`CSPC_CTRL_SIE] &&
                  (bus_evt.rx_ok || bus_evt.tx_ok || run_seen ||
                   (bus_evt.frame_error && !err_in_frame) ||
                   (low_power && next_mode == cspc_pkg::CSPC_RUN))) ||
                 (ctrl[`CSPC_CTRL_EIE] &&
                  (warn_prev != error_warning_flag ||
                   bus_off_flag_prev != bus_off_flag))) begin
      stat_pend <= 1'b1; // RQ4 RQ12
    end else if (rd_acc && hit(idx, `CSPC_IDX_STATUS) && stat_seen) begin
      stat_pend <= 1'b0; // RQ11
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      obj_pend <= 15'h0000;
    end else begin
      for (int i = 0; i < 15; i++) begin
        if ((obj_tx_event[i] && object_tx_irq_enable[i]) ||
            (obj_rx_event[i] && object_rx_irq_enable[i])) begin
          obj_pend[i] <= 1'b1; // RQ13
        end else if (rd_acc && !hold && hit(idx, `CSPC_IDX_INTR) &&
                     readdata[7:0] == `CSPC_INT_OBJ_BASE + 8'(i)) begin
          obj_pend[i] <= 1'b0;
        end
      end
    end
  end

  // Pending codes stay stored while the global enable is off.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      int_main_n      <= 1'b1;
      int_alt_n       <= 1'b1;
      half_ref_enable <= 1'b0;
    end else begin
      int_main_n      <= !(irq_cond && !host_ctl[`CSPC_HOST_MUX]); // RQ18
      int_alt_n       <= !(irq_cond && host_ctl[`CSPC_HOST_MUX]); // RQ18
      half_ref_enable <= host_ctl[`CSPC_HOST_MUX] &&
                         mode != cspc_pkg::CSPC_PDOWN; // RQ18
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bus_enable          <= 1'b0;
      obj_access_enable   <= 1'b0;
      osc_enable          <= 1'b1;
      config_write_unlock <= 1'b0;
    end else begin
      bus_enable <= !ctrl[`CSPC_CTRL_INIT] && !bus_off_flag && !low_power &&
                    settle_cnt == 20'h0_0000; // RQ1 RQ21
      obj_access_enable   <= !low_power && !hold; // RQ19
      osc_enable          <= !low_power; // RQ19
      config_write_unlock <= ctrl[`CSPC_CTRL_CCE];
    end
  end

  cspc_clock_div u_clock_div (
    .clk                 (clk),
    .rst_n               (rst_n),
    .system_clock_halver (host_ctl[`CSPC_HOST_DSC]),
    .memory_clock_halver (host_ctl[`CSPC_HOST_DMC]),
    .clock_output_enable (host_ctl[`CSPC_HOST_CEN]),
    .stop                (low_power),
    .system_tick         (system_tick),
    .memory_tick         (memory_tick),
    .clock_out           (clock_out)
  );

  property p_bus_off_silent;
    @(posedge clk) disable iff (!rst_n)
    bus_off_flag |=> !bus_enable;
  endproperty
  a_bus_off_silent: assert property (p_bus_off_silent) // RQ1
    else $error("Bus enabled while bus-off.");

  property p_warn_level;
    @(posedge clk) disable iff (!rst_n)
    (err_cnt.tx_count >= 9'h060) |=> error_warning_flag;
  endproperty
  a_warn_level: assert property (p_warn_level) // RQ3
    else $error("Warning flag missing at count 96.");

  property p_irq_needs_ie;
    @(posedge clk) disable iff (!rst_n)
    $fell(int_main_n) |-> $past(ctrl[1]);
  endproperty
  a_irq_needs_ie: assert property (p_irq_needs_ie) // RQ4
    else $error("Interrupt raised with global enable clear.");

  property p_host_in_reset;
    @(posedge clk) disable iff (!rst_n)
    (read && waitrequest && hold && idx == 7'h02) |=> readdata[7:0] == 8'hE1;
  endproperty
  a_host_in_reset: assert property (p_host_in_reset) // RQ14
    else $error("Host register not E1 during reset.");

  property p_sleep_wake_low;
    @(posedge clk) disable iff (!rst_n)
    mode == cspc_pkg::CSPC_SLEEP && next_mode == cspc_pkg::CSPC_SLEEP |=>
      !wakeup_flag;
  endproperty
  a_sleep_wake_low: assert property (p_sleep_wake_low) // RQ5
    else $error("Wake flag high while asleep.");

  property p_alt_pin_quiet;
    @(posedge clk) disable iff (!rst_n)
    !host_ctl[2] |=> int_alt_n;
  endproperty
  a_alt_pin_quiet: assert property (p_alt_pin_quiet) // RQ18
    else $error("Alternate pin driven without low speed select.");

  property p_bus_off_flag_sets_hold;
    @(posedge clk) disable iff (!rst_n)
    $rose(bus_off_flag) |-> ctrl[0];
  endproperty
  a_bus_off_flag_sets_hold: assert property (p_bus_off_flag_sets_hold) // RQ23
    else $error("Going bus-off left the hold bit clear.");

  property p_power_down_wins;
    @(posedge clk) disable iff (!rst_n)
    host_ctl[4] |=> mode == cspc_pkg::CSPC_PDOWN ##1 !osc_enable;
  endproperty
  a_power_down_wins: assert property (p_power_down_wins) // RQ24
    else $error("Power down not entered.");
endmodule

// ---- sim/cspc_bus_model.sv ----
`timescale 1ns/1ps
module cspc_bus_model (
  // Clock.
  input  wire logic                  clk,
  // Bus side.
  output cspc_pkg::cspc_bus_evt_type bus_evt,
  output cspc_pkg::cspc_err_cnt_type err_cnt,
  output logic                       can_rx_pin
);
  initial begin
    bus_evt = '0;
    err_cnt = '0;
    can_rx_pin = 1'b1;
  end
  // One engine event, held for exactly one clock.
  task automatic ev(input logic [8:0] e);
    @(posedge clk);
    bus_evt <= e;
    @(posedge clk);
    bus_evt <= '0;
  endtask
  task automatic cnt(input logic [8:0] c);
    @(posedge clk);
    err_cnt <= {c, 9'h000};
  endtask
  // Idle bus: recessive bits with a gap between strobes.
  task automatic idle(input int n);
    repeat (n) ev(9'h003);
  endtask
  // A short dominant level, long enough to pass the pin synchroniser.
  task automatic wake();
    @(posedge clk);
    can_rx_pin <= 1'b0;
    repeat (4) @(posedge clk);
    can_rx_pin <= 1'b1;
  endtask
endmodule

// ---- sim/tb_can_status_and_power_control.sv ----
`timescale 1ns/1ps
module tb_can_status_and_power_control;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [8:0]  address = '0;
  logic        read = 1'b0;
  logic        write = 1'b0;
  logic [31:0] writedata = '0;
  logic [31:0] readdata;
  logic        waitrequest;
  logic [14:0] o_rx = '0;
  logic [14:0] o_en = '0;
  logic        int_main_n, int_alt_n, half_ref, osc_en, obj_acc, bus_en;
  logic        s_tick, m_tick, clock_out;
  logic [7:0]  q;
  logic [3:0]  be = 4'h1;
  logic [14:0] o_tx = '0;
  logic [14:0] o_ten = '0;
  logic        ctr_rst, cwu;
  int          n_rst = 0;
  wire         can_rx_pin;
  int          errors = 0;
  int          n_checks = 0;
  cspc_pkg::cspc_bus_evt_type bus_evt;
  cspc_pkg::cspc_err_cnt_type err_cnt;
  always #5 clk = ~clk;
  always @(posedge clk) begin
    if (ctr_rst === 1'b1) begin
      n_rst++;
    end
  end
  cspc_bus_model i_cspc_bus_model (.clk(clk), .bus_evt(bus_evt),
    .err_cnt(err_cnt), .can_rx_pin(can_rx_pin));
  cspc_core #(.SETTLE_CYCLES(20)) i_cspc_core (.clk(clk), .rst_n(rst_n),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .byteenable(be), .readdata(readdata), .waitrequest(waitrequest),
    .bus_evt(bus_evt), .err_cnt(err_cnt), .counters_reset(ctr_rst),
    .bus_enable(bus_en), .obj_tx_event(o_tx), .obj_rx_event(o_rx),
    .object_tx_irq_enable(o_ten), .object_rx_irq_enable(o_en),
    .obj_access_enable(obj_acc), .config_write_unlock(cwu),
    .can_rx_pin(can_rx_pin), .int_main_n(int_main_n), .int_alt_n(int_alt_n),
    .half_ref_enable(half_ref), .osc_enable(osc_en), .system_tick(s_tick),
    .memory_tick(m_tick), .clock_out(clock_out));
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    n_checks++;
    if (s !== e) begin
      errors++;
      $display("ERROR at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  // One bus transfer; the request stands until waitrequest is seen low.
  task automatic op(input logic w, input logic [6:0] i, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    address <= {i, 2'b00};
    writedata <= {24'h00_0000, d};
    write <= w;
    read <= ~w;
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 40);
    if (waitrequest !== 1'b0) begin
      errors++;
      give_verdict();
    end
    q = readdata[7:0];
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic ticks(input logic [7:0] h, input int es, input int em);
    int s;
    int m;
    s = 0;
    m = 0;
    op(1, 7'h02, h);
    repeat (8) @(negedge clk);
    repeat (40) begin
      @(negedge clk);
      s += s_tick;
      m += m_tick;
    end
    chk(8'(s), 8'(es));
    chk(8'(m), 8'(em));
  endtask
  initial begin
    int n;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    op(0, 7'h02, 0); chk(q, 8'hE1);
    op(0, 7'h01, 0); chk(q, 8'h00);
    n = 0;
    do begin
      op(0, 7'h02, 0);
      n++;
    end while (q[7] !== 1'b0 && n < 30);
    chk(q, 8'h61);
    op(0, 7'h00, 0); chk(q, 8'h01);
    op(0, 7'h03, 0); chk(q, 8'h00);
    $display("reset test done");
    op(1, 7'h00, 8'h06);
    for (int c = 1; c < 7; c++) begin
      i_cspc_bus_model.ev(9'h100);
      i_cspc_bus_model.ev({2'b01, 3'(c), 4'h0});
      op(0, 7'h01, 0); chk(q & 8'h07, 8'(c));
    end
    i_cspc_bus_model.ev(9'h100);
    i_cspc_bus_model.ev(9'h0A0);
    i_cspc_bus_model.ev(9'h0E0);
    op(0, 7'h01, 0); chk(q & 8'h07, 8'h02);
    i_cspc_bus_model.ev(9'h008);
    repeat (3) @(negedge clk);
    chk(int_main_n, 1'b0);
    op(0, 7'h5F, 0); chk(q, 8'h01);
    op(0, 7'h01, 0); chk(q, 8'h10);
    op(0, 7'h5F, 0); chk(q, 8'h00);
    i_cspc_bus_model.ev(9'h004);
    op(0, 7'h01, 0); chk(q, 8'h18);
    i_cspc_bus_model.ev(9'h008);
    repeat (3) @(negedge clk);
    chk(int_main_n, 1'b0);
    op(1, 7'h01, 8'h07);
    op(0, 7'h01, 0); chk(q, 8'h07);
    $display("status test done");
    op(1, 7'h00, 8'h0A);
    i_cspc_bus_model.cnt(9'h060);
    repeat (4) @(negedge clk);
    chk(int_main_n, 1'b0);
    op(0, 7'h01, 0); chk(q & 8'hC0, 8'h40);
    i_cspc_bus_model.cnt(9'h100);
    repeat (4) @(negedge clk);
    chk(bus_en, 1'b0);
    op(0, 7'h01, 0); chk(q[7], 1'b1);
    op(0, 7'h00, 0); chk(q, 8'h0B);
    i_cspc_bus_model.cnt(9'h000);
    op(1, 7'h00, 8'h0A);
    i_cspc_bus_model.idle(1397);
    op(0, 7'h01, 0); chk(q & 8'h87, 8'h85);
    i_cspc_bus_model.idle(11);
    op(0, 7'h01, 0); chk(q & 8'h87, 8'h05);
    chk(bus_en, 1'b1);
    chk(8'(n_rst), 8'h01);
    $display("bus-off test done");
    op(1, 7'h00, 8'h4A);
    op(1, 7'h2F, 8'h00);
    op(1, 7'h4F, 8'h00);
    op(0, 7'h00, 0); chk(q, 8'h4A);
    chk(cwu, 1'b1);
    op(1, 7'h00, 8'h0A);
    op(1, 7'h02, 8'h69);
    repeat (4) @(negedge clk);
    chk({osc_en, obj_acc}, 2'b00);
    op(0, 7'h01, 0); chk(q[5], 1'b0);
    i_cspc_bus_model.wake();
    repeat (4) @(negedge clk);
    chk(bus_en, 1'b0);
    op(0, 7'h02, 0); chk(q, 8'h61);
    repeat (25) @(negedge clk);
    chk(bus_en, 1'b1);
    op(0, 7'h01, 0); chk(q[5], 1'b1);
    op(0, 7'h01, 0); chk(q[5], 1'b0);
    op(1, 7'h02, 8'h79);
    repeat (4) @(negedge clk);
    chk({osc_en, obj_acc}, 2'b00);
    i_cspc_bus_model.wake();
    op(0, 7'h02, 0); chk(q, 8'h79);
    op(1, 7'h02, 8'h61);
    op(0, 7'h02, 0); chk(q, 8'h61);
    op(0, 7'h01, 0); chk(q[5], 1'b1);
    chk(osc_en, 1'b1);
    $display("low power test done");
    op(1, 7'h00, 8'h06);
    op(1, 7'h02, 8'h65);
    i_cspc_bus_model.ev(9'h008);
    repeat (3) @(negedge clk);
    chk({int_alt_n, int_main_n, half_ref}, 3'b011);
    op(0, 7'h01, 0);
    ticks(8'h61, 20, 10);
    ticks(8'h21, 40, 20);
    ticks(8'h41, 20, 20);
    ticks(8'h01, 40, 40);
    ticks(8'h00, 40, 40);
    chk(clock_out, 1'b0);
    $display("pin and clock test done");
    op(1, 7'h02, 8'h01);
    op(1, 7'h00, 8'h02);
    be <= 4'h0;
    op(1, 7'h00, 8'h00);
    be <= 4'h1;
    op(0, 7'h00, 0); chk(q, 8'h02);
    o_en <= 15'h0003;
    o_rx <= 15'h0003;
    o_ten <= 15'h0004;
    o_tx <= 15'h0004;
    @(posedge clk);
    o_rx <= 15'h0000;
    o_tx <= 15'h0000;
    repeat (4) @(negedge clk);
    chk(int_main_n, 1'b0);
    op(0, 7'h5F, 0); chk(q, 8'h02);
    op(0, 7'h5F, 0); chk(q, 8'h03);
    op(0, 7'h5F, 0); chk(q, 8'h04);
    op(0, 7'h5F, 0); chk(q, 8'h00);
    $display("object interrupt test done");
    give_verdict();
  end
endmodule
